// *** hdl/rsse_pkg.sv ***
// Shared constants, types and decode for the rotate/subtract/sleep datapath
package rsse_pkg;

  localparam int DATA_W   = 8;
  localparam int FILE_AW  = 7;
  localparam int FILE_NUM = 128;

  // Register byte offsets on the bus
  localparam logic [11:0] OFS_CMD  = 12'h000;
  localparam logic [11:0] OFS_ACC  = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_WDOG = 12'h00C;
  localparam logic [11:0] OFS_FILE = 12'h200;

  // Command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_DST_BIT = 2;
  localparam int CMD_ARG_LSB = 8;

  // Status bit positions
  localparam int ST_C   = 0;
  localparam int ST_HC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_PWD = 3;
  localparam int ST_TMO = 4;
  localparam int ST_SLP = 5;

  // Reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic       RST_PWD = 1'b1;
  localparam logic       RST_TMO = 1'b1;

  typedef enum logic [1:0] {
    OP_ROTL,
    OP_ROTR,
    OP_SUBL,
    OP_SLEEP
  } rsse_op_e;

  typedef enum logic {
    ST_RUN,
    ST_ASLEEP
  } rsse_state_e;

  typedef struct packed {
    rsse_op_e   op;
    logic       dest;
    logic [7:0] arg;
  } rsse_cmd_s;

  typedef struct packed {
    logic z;
    logic hc;
    logic c;
  } rsse_flags_s;

  function automatic rsse_cmd_s rsse_cmd_decode(input logic [31:0] d);
    rsse_cmd_s r;
    r.op   = rsse_op_e'(d[CMD_OP_LSB +: 2]);
    r.dest = d[CMD_DST_BIT];
    r.arg  = d[CMD_ARG_LSB +: 8];
    return r;
  endfunction

endpackage

// *** hdl/rsse_alu.sv ***
// Combinational result and flag logic for rotates and literal subtract
`timescale 1ns/1ns
module rsse_alu
  import rsse_pkg::*;
(
  input  rsse_op_e    op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] fval,
  input  wire logic [7:0] lit,
  input  wire logic       carry_in,
  output logic [7:0]  result,
  output rsse_flags_s flags_out
);

  logic [8:0] diff_full;
  logic [4:0] diff_low;
  logic [7:0] rot_l;
  logic [7:0] rot_r;

  assign rot_l     = {fval[6:0], carry_in};
  assign rot_r     = {carry_in, fval[7:1]};
  // Borrow out of the top bit means the accumulator exceeded the literal
  assign diff_full = {1'b0, lit} - {1'b0, acc};
  assign diff_low  = {1'b0, lit[3:0]} - {1'b0, acc[3:0]};

  assign result = (op == OP_ROTL) ? rot_l :
                  (op == OP_ROTR) ? rot_r : diff_full[7:0];

  assign flags_out.c  = (op == OP_ROTL) ? fval[7] :
                        (op == OP_ROTR) ? fval[0] : ~diff_full[8];
  assign flags_out.hc = ~diff_low[4];
  assign flags_out.z  = (diff_full[7:0] == 8'h00);

endmodule // rsse_alu

// *** hdl/rsse_exec.sv ***
// Execution datapath with Wishbone register access
// Notes on behaviour
// - Rotate left: carry into bit 0, bit 7 out to carry, file 0..127.
// - Rotate left result goes to accumulator if dest 0, file if dest 1.
// - Rotate right: carry into bit 7, bit 0 out to carry, file 0..127.
// - Rotate right result goes to accumulator if dest 0, file if dest 1.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears power-down flag, sets timeout flag, other flags kept.
// - After sleep, execution halts and the oscillator is stopped.
// - Literal subtract stores literal minus accumulator in accumulator.
// - Carry set when acc <= literal; half carry likewise on low nibbles.
`timescale 1ns/1ns
module rsse_exec
  import rsse_pkg::*;
#(
  parameter int PRE_W = 8,
  parameter int WDOG_W = 8
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             osc_stop
);

  generate
    if (PRE_W < 1 || PRE_W > 16 || WDOG_W < 1 || WDOG_W > 16)
    begin : g_bad_width
      $error("rsse_exec: PRE_W and WDOG_W must lie in 1..16");
    end
  endgenerate

  rsse_state_e       state;
  logic [7:0]        acc;
  rsse_flags_s       flags;
  logic              powerdown_flag;
  logic              timeout_flag;
  logic [PRE_W-1:0]  prescaler;
  logic [WDOG_W-1:0] watchdog_counter;
  logic [7:0]        file_mem [FILE_NUM];

  wire               req_new  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire               wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire               hit_cmd  = (wb_adr_i == OFS_CMD);
  wire               hit_acc  = (wb_adr_i == OFS_ACC);
  wire               hit_stat = (wb_adr_i == OFS_STAT);
  wire               hit_wdog = (wb_adr_i == OFS_WDOG);
  wire               hit_file = (wb_adr_i[11:9] == OFS_FILE[11:9])
                                & (wb_adr_i[1:0] == 2'b00);
  wire [FILE_AW-1:0] bus_idx  = wb_adr_i[2 +: FILE_AW];

  wire rsse_cmd_s    cmd      = rsse_cmd_decode(wb_dat_i);
  wire [FILE_AW-1:0] faddr    = cmd.arg[FILE_AW-1:0];
  wire [7:0]         fval     = file_mem[faddr];
  // Commands are refused while asleep; the bus still answers
  wire               exec     = wr_fire & hit_cmd & wb_sel_i[0]
                                & (state == ST_RUN);
  wire               is_rot   = (cmd.op == OP_ROTL) | (cmd.op == OP_ROTR);
  wire               ex_rot   = exec & is_rot;
  wire               ex_sub   = exec & (cmd.op == OP_SUBL);
  wire               ex_slp   = exec & (cmd.op == OP_SLEEP);
  wire               rot_to_f = ex_rot & cmd.dest;
  wire               rot_to_w = ex_rot & ~cmd.dest;
  wire               bus_wr0  = wr_fire & wb_sel_i[0];

  logic [7:0]        alu_res;
  rsse_flags_s       alu_flags;

  rsse_alu u_alu (
    .op        (cmd.op),
    .acc       (acc),
    .fval      (fval),
    .lit       (cmd.arg),
    .carry_in  (flags.c),
    .result    (alu_res),
    .flags_out (alu_flags)
  );

  wire [7:0]  stat_rd = {2'b00, state == ST_ASLEEP, timeout_flag,
                         powerdown_flag, flags.z, flags.hc, flags.c};
  wire [31:0] wdog_rd = (32'(prescaler) << 16) | 32'(watchdog_counter);
  wire [31:0] next_rd = hit_acc  ? {24'h000000, acc} :
                        hit_stat ? {24'h000000, stat_rd} :
                        hit_wdog ? wdog_rd :
                        hit_file ? {24'h000000, file_mem[bus_idx]} :
                        32'h00000000;

  // Bus slave: ack one cycle after request, held for one cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req_new;
      if (req_new)
        wb_dat_o <= next_rd;
    end
  end

  // File registers, one flip-flop byte per address
  genvar gi;
  generate
    for (gi = 0; gi < FILE_NUM; gi++)
    begin : g_file
      wire bus_hit = bus_wr0 & hit_file & (bus_idx == FILE_AW'(gi));
      wire ex_hit  = rot_to_f & (faddr == FILE_AW'(gi));
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          file_mem[gi] <= 8'h00;
        else if (ex_hit)
          file_mem[gi] <= alu_res;
        else if (bus_hit)
          file_mem[gi] <= wb_dat_i[7:0];
      end
    end
  endgenerate

  // Accumulator and arithmetic flags
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      acc   <= RST_ACC;
      flags <= '0;
    end
    else
    begin
      if (ex_sub | rot_to_w)
        acc <= alu_res;
      else if (bus_wr0 & hit_acc)
        acc <= wb_dat_i[7:0];
      // Rotates touch only carry
      if (ex_rot)
        flags.c <= alu_flags.c;
      else if (ex_sub)
        flags <= alu_flags;
      else if (bus_wr0 & hit_stat)
        flags <= {wb_dat_i[ST_Z], wb_dat_i[ST_HC], wb_dat_i[ST_C]};
    end
  end

  // Sleep entry; only reset brings the core back
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state          <= ST_RUN;
      osc_stop       <= 1'b0;
      powerdown_flag <= RST_PWD;
      timeout_flag   <= RST_TMO;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          if (ex_slp)
          begin
            state          <= ST_ASLEEP;
            osc_stop       <= 1'b1;
            powerdown_flag <= 1'b0;
            timeout_flag   <= 1'b1;
          end
        end
        ST_ASLEEP: state <= ST_ASLEEP;
        default:   state <= ST_RUN;
      endcase
    end
  end

  // Watchdog: counts while running, frozen with the oscillator
  wire pre_wrap = (prescaler == {PRE_W{1'b1}});
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prescaler        <= '0;
      watchdog_counter <= '0;
    end
    else if (ex_slp)
    begin
      prescaler        <= '0;
      watchdog_counter <= '0;
    end
    else if (state == ST_RUN)
    begin
      prescaler <= prescaler + PRE_W'(1);
      if (pre_wrap)
        watchdog_counter <= watchdog_counter + WDOG_W'(1);
    end
  end

  // Checks
  sequence s_sleep_cmd;
    exec && cmd.op == OP_SLEEP;
  endsequence

  sequence s_frozen;
    osc_stop && state == ST_ASLEEP && watchdog_counter == '0
      && prescaler == '0;
  endsequence

  a_rotl_to_acc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && cmd.op == OP_ROTL && !cmd.dest |=>
      acc == {$past(fval[6:0]), $past(flags.c)} && flags.c == $past(fval[7])
      && $stable(flags.z) && $stable(flags.hc))
    else $error("rotate left result or carry wrong");

  a_rotl_to_file: assert property (@(posedge ref_clk) disable iff (rst)
    exec && cmd.op == OP_ROTL && cmd.dest |=>
      file_mem[$past(faddr)] == {$past(fval[6:0]), $past(flags.c)}
      && $stable(acc))
    else $error("rotate left file destination wrong");

  a_rotr_to_acc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && cmd.op == OP_ROTR && !cmd.dest |=>
      acc == {$past(flags.c), $past(fval[7:1])} && flags.c == $past(fval[0])
      && $stable(flags.z) && $stable(flags.hc))
    else $error("rotate right result or carry wrong");

  a_rotr_to_file: assert property (@(posedge ref_clk) disable iff (rst)
    exec && cmd.op == OP_ROTR && cmd.dest |=>
      file_mem[$past(faddr)] == {$past(flags.c), $past(fval[7:1])}
      && $stable(acc))
    else $error("rotate right file destination wrong");

  a_sleep_wdog: assert property (@(posedge ref_clk) disable iff (rst)
    s_sleep_cmd |=> s_frozen [*4])
    else $error("watchdog not cleared and held by sleep");

  a_sleep_flags: assert property (@(posedge ref_clk) disable iff (rst)
    s_sleep_cmd |=> !powerdown_flag && timeout_flag && $stable(flags))
    else $error("sleep status flags wrong");

  a_sleep_halt: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_ASLEEP && wr_fire && hit_cmd |=> $stable(acc)
      && $stable(flags) && osc_stop)
    else $error("command executed while asleep");

  a_sub_value: assert property (@(posedge ref_clk) disable iff (rst)
    exec && cmd.op == OP_SUBL |=>
      acc == 8'($past(cmd.arg) - $past(acc)))
    else $error("literal subtract result wrong");

  a_sub_carry: assert property (@(posedge ref_clk) disable iff (rst)
    exec && cmd.op == OP_SUBL |=>
      flags.c == ($past(acc) <= $past(cmd.arg))
      && flags.hc == ($past(acc[3:0]) <= $past(cmd.arg[3:0])))
    else $error("literal subtract carry or half carry wrong");

  a_sub_zero: assert property (@(posedge ref_clk) disable iff (rst)
    exec && cmd.op == OP_SUBL |=>
      flags.z == ($past(cmd.arg) == $past(acc)))
    else $error("literal subtract zero flag wrong");

endmodule // rsse_exec

// *** bench/rsse_exec_tb_top.sv ***
// Self-checking bench for the rotate/subtract/sleep datapath
`timescale 1ns/1ns
module rsse_exec_tb_top;
  import rsse_pkg::*;

  typedef struct packed {
    logic [15:0] cmd;
    logic [7:0]  a0, f0, st0, ea, ef, est;
  } rsse_row_s;

  // Cmd, acc, file, status before; acc, file, status after
  localparam rsse_row_s ROWS [8] = '{
    {16'h7F00, 8'h00, 8'hE6, 8'h06, 8'hCC, 8'hE6, 8'h1F},
    {16'h7F04, 8'h55, 8'h80, 8'h01, 8'h55, 8'h01, 8'h19},
    {16'h7F01, 8'h00, 8'h01, 8'h01, 8'h80, 8'h01, 8'h19},
    {16'h7F05, 8'h33, 8'h02, 8'h06, 8'h33, 8'h01, 8'h1E},
    {16'h5A02, 8'h5A, 8'hAA, 8'h00, 8'h00, 8'hAA, 8'h1F},
    {16'h0002, 8'h01, 8'hAA, 8'h07, 8'hFF, 8'hAA, 8'h18},
    {16'hFF02, 8'h0F, 8'hAA, 8'h00, 8'hF0, 8'hAA, 8'h1B},
    {16'h1002, 8'h01, 8'hAA, 8'h00, 8'h0F, 8'hAA, 8'h19}
  };
  localparam logic [11:0] FTOP = 12'h3FC;

  logic        ref_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [11:0] adr      = 12'h000;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] dat      = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        osc_stop;
  logic [31:0] q;
  int          error_cnt   = 0;
  int          checks_done = 0;

  always #20 ref_clk = ~ref_clk;

  rsse_exec uut (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wb_cyc_i (cyc),
    .wb_stb_i (stb),
    .wb_we_i  (we),
    .wb_adr_i (adr),
    .wb_sel_i (sel),
    .wb_dat_i (dat),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .osc_stop (osc_stop)
  );

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      $display("BAD ack timeout at %h", a);
      final_report();
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(nm, e, q);
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial
  begin
    do_reset();
    // Reset values
    rd("acc", OFS_ACC, 32'h0000_0000);
    rd("status", OFS_STAT, 32'h0000_0018);
    rd("file", FTOP, 32'h0000_0000);
    chk("osc_stop", 32'h0000_0000, {31'h0, osc_stop});
    $display("Test reset values done");

    foreach (ROWS[i])
    begin
      wb(1'b1, OFS_ACC, {24'h0, ROWS[i].a0}, 4'hF);
      wb(1'b1, FTOP, {24'h0, ROWS[i].f0}, 4'hF);
      wb(1'b1, OFS_STAT, {24'h0, ROWS[i].st0}, 4'hF);
      wb(1'b1, OFS_CMD, {16'h0, ROWS[i].cmd}, 4'hF);
      rd("acc", OFS_ACC, {24'h0, ROWS[i].ea});
      rd("file", FTOP, {24'h0, ROWS[i].ef});
      rd("status", OFS_STAT, {24'h0, ROWS[i].est});
      $display("Test row %0d done", i);
    end

    // Unmapped place and a write with the low byte lane off
    wb(1'b1, 12'h100, 32'h0000_00FF, 4'hF);
    rd("unmapped", 12'h100, 32'h0000_0000);
    wb(1'b1, OFS_ACC, 32'h0000_0077, 4'hE);
    rd("acc lane", OFS_ACC, 32'h0000_000F);
    $display("Test refusals done");

    // Lowest file address, rotate left back into the file
    wb(1'b1, OFS_FILE, 32'h0000_0081, 4'hF);
    wb(1'b1, OFS_STAT, 32'h0000_0000, 4'hF);
    wb(1'b1, OFS_CMD, 32'h0000_0004, 4'hF);
    rd("file0", OFS_FILE, 32'h0000_0002);
    rd("file top", FTOP, 32'h0000_00AA);
    rd("acc kept", OFS_ACC, 32'h0000_000F);
    rd("status", OFS_STAT, 32'h0000_0019);
    $display("Test file bounds done");

    // Sleep with counters running and C, Z set beforehand
    repeat (300) @(posedge ref_clk);
    wb(1'b1, OFS_STAT, 32'h0000_0005, 4'hF);
    wb(1'b1, OFS_CMD, 32'h0000_0003, 4'hF);
    rd("wdog", OFS_WDOG, 32'h0000_0000);
    rd("status", OFS_STAT, 32'h0000_0035);
    chk("osc_stop", 32'h0000_0001, {31'h0, osc_stop});
    // Halted: a command is ignored and counters stay frozen
    wb(1'b1, OFS_CMD, 32'h0000_5A02, 4'hF);
    repeat (40) @(posedge ref_clk);
    rd("acc", OFS_ACC, 32'h0000_000F);
    rd("wdog", OFS_WDOG, 32'h0000_0000);
    $display("Test sleep done");

    // Only a reset leaves sleep
    do_reset();
    chk("osc_stop", 32'h0000_0000, {31'h0, osc_stop});
    rd("status", OFS_STAT, 32'h0000_0018);
    $display("Test second reset done");
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("BAD run timeout");
    final_report();
  end
endmodule // rsse_exec_tb_top
